// ### src/tcd_pkg.sv
// package: constants of the thermocouple diagnostic record
package tcd_pkg;
    // ****************************************
    // record addressing
    // ****************************************
    localparam logic [7:0]  SET_SHORT     = 8'h00;
    localparam logic [7:0]  SET_FULL      = 8'h01;
    localparam logic [15:0] IDX_SHORT     = 16'h2F00;
    localparam logic [15:0] IDX_FULL      = 16'h2F01;
    localparam logic [7:0]  SUB_FIRST     = 8'h02;
    localparam logic [7:0]  SUB_CLASS     = 8'h03;
    localparam logic [7:0]  SUB_RSVD2     = 8'h04;
    localparam logic [7:0]  SUB_INTERR    = 8'h05;
    localparam logic [7:0]  SUB_KIND      = 8'h06;
    localparam logic [7:0]  SUB_NUMBITS   = 8'h07;
    localparam logic [7:0]  SUB_CHANNEL_COUNT     = 8'h08;
    localparam logic [7:0]  SUB_GRPERR    = 8'h09;
    localparam logic [7:0]  SUB_CH0       = 8'h0A;
    localparam logic [7:0]  SUB_CH1       = 8'h0B;
    localparam logic [7:0]  SUB_UNUSED_LO = 8'h0C;
    localparam logic [7:0]  SUB_UNUSED_HI = 8'h11;
    localparam logic [7:0]  SUB_STAMP     = 8'h13;
    localparam logic [4:0]  SHORT_LEN     = 5'h04;
    localparam logic [4:0]  FULL_LEN      = 5'h16;
    // ****************************************
    // fixed values and field positions
    // ****************************************
    localparam logic [3:0]  CLASS_ANALOG  = 4'h5;
    localparam int          CLASS_CHINFO  = 4;
    localparam logic [7:0]  CLASS_RESET   = 8'h15;
    localparam logic [6:0]  KIND_AI       = 7'h71;
    localparam logic [7:0]  NUM_BITS      = 8'h08;
    localparam logic [7:0]  NUM_CH        = 8'h02;
    localparam int          ME_FAIL       = 0;
    localparam int          ME_INT        = 1;
    localparam int          ME_EXT        = 2;
    localparam int          ME_CHAN       = 3;
    localparam int          ME_AUX        = 4;
    localparam int          ME_PARAM      = 7;
    localparam int          IE_OVF        = 3;
    localparam int          IE_COMM       = 4;
    localparam int          CE_PARAM      = 0;
    localparam int          CE_BREAK      = 4;
    localparam int          CE_UNDER      = 6;
    localparam int          CE_OVER       = 7;
    // ****************************************
    // timing
    // ****************************************
    localparam int          CLK_MHZ       = 100;
    localparam int          TICK_US       = 1;
    localparam int          TICK_CYC      = CLK_MHZ * TICK_US;
endpackage : tcd_pkg

// ### src/tcd_diag_record.sv
// module: diagnostic record of a two-channel thermocouple input
// Functional notes
// - error byte bits 0-3: failure, internal, external, any channel error
// - error byte bit 4 aux supply missing, bit 7 param error, 6:5 reserved
// - info byte bits 3:0 hold analog class 0101b, 7:5 reserved
// - info byte bit 4 flags channel info present, default 15h
// - second diagnostic byte bit 3 buffer overflow, bit 4 comm error
// - channel kind byte reports analog input 71h, bit 7 reserved
// - diagnostic bits per channel reads constant 08h
// - channel count reads constant 02h
// - group error byte bit 0 group 0, bit 1 group 1
// - channel byte bit 0 parameterization error, bits 3:1 reserved
// - channel byte bit 4 wire break, bit 5 reserved
// - channel byte bit 6 underflow, bit 7 overflow
// - ticker value latched into four-byte timestamp on a diagnostic event
// - microsecond timer cleared at power-on, counts up from zero
// - timer is 32 bits and wraps to zero
// - error bytes, reserved bytes and timestamp default to zero
// - record bytes from subindex 02h, timestamp at 13h, set 01h/2F01h
// - first four bytes also readable through set 00h or 2F00h
// - no interrupt; channel error lights its channel indicator and enters record
`timescale 1ns/1ps
module tcd_diag_record (
    input  wire logic        CLK_SYS,
    input  wire logic        RSTN,
    input  wire logic        MOD_FAIL,
    input  wire logic        INT_ERR,
    input  wire logic        EXT_ERR,
    input  wire logic        AUX_MISSING,
    input  wire logic        PARAM_ERR,
    input  wire logic        BUF_OVERFLOW,
    input  wire logic        COMM_ERR,
    input  wire logic [1:0]  CH_PARAM_ERR,
    input  wire logic [1:0]  CH_WIRE_BREAK,
    input  wire logic [1:0]  CH_UNDERFLOW,
    input  wire logic [1:0]  CH_OVERFLOW,
    input  wire logic        RD_REQ,
    input  wire logic        RD_BY_INDEX,
    input  wire logic [7:0]  RECORD_SET_NUMBER,
    input  wire logic [15:0] OBJECT_INDEX,
    input  wire logic [7:0]  OBJECT_SUBINDEX,
    output logic             RD_ACK,
    output logic             RD_ERR,
    output logic [7:0]       RD_DATA,
    output logic [1:0]       CH_LED,
    output logic [31:0]      US_TICKER
);
    // ****************************************
    // microsecond ticker
    // ****************************************
    logic [6:0]  pre_r;
    logic [6:0]  pre_nxt;
    logic [31:0] tick_r;
    logic [31:0] tick_nxt;

    always_comb
    begin
        pre_nxt  = pre_r + 7'h01;
        tick_nxt = tick_r;
        if (pre_r == 7'(tcd_pkg::TICK_CYC - 1))
        begin
            pre_nxt  = 7'h00;
            tick_nxt = tick_r + 32'h0000_0001;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            pre_r  <= 7'h00;
            tick_r <= 32'h0000_0000;
        end
        else
        begin
            pre_r  <= pre_nxt;
            tick_r <= tick_nxt;
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [7:0] new_bits(input logic [7:0] nxt_v,
                                            input logic [7:0] cur_v);
        return nxt_v & ~cur_v;
    endfunction : new_bits

    function automatic logic addr_hit(input logic        by_idx,
                                      input logic [7:0]  set_v,
                                      input logic [15:0] idx_v,
                                      input logic [7:0]  want_set,
                                      input logic [15:0] want_idx);
        return by_idx ? (idx_v == want_idx) : (set_v == want_set);
    endfunction : addr_hit

    function automatic logic sub_in(input logic [7:0] sub_v,
                                    input logic [4:0] len_v);
        return (sub_v >= tcd_pkg::SUB_FIRST)
            && (sub_v < tcd_pkg::SUB_FIRST + {3'h0, len_v});
    endfunction : sub_in

    // ****************************************
    // channel bytes
    // ****************************************
    logic [7:0]  chan_err_r [2];
    logic [7:0]  chan_err_nxt [2];
    logic [7:0]  grp_err_r;
    logic [7:0]  grp_err_nxt;

    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            chan_err_nxt[i] = 8'h00;
            chan_err_nxt[i][tcd_pkg::CE_PARAM] = CH_PARAM_ERR[i];
            chan_err_nxt[i][tcd_pkg::CE_BREAK] = CH_WIRE_BREAK[i];
            chan_err_nxt[i][tcd_pkg::CE_UNDER] = CH_UNDERFLOW[i];
            chan_err_nxt[i][tcd_pkg::CE_OVER]  = CH_OVERFLOW[i];
        end
        grp_err_nxt = {6'h00, |chan_err_nxt[1], |chan_err_nxt[0]};
    end

    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            chan_err_r[0] <= 8'h00;
            chan_err_r[1] <= 8'h00;
            grp_err_r     <= 8'h00;
        end
        else
        begin
            chan_err_r[0] <= chan_err_nxt[0];
            chan_err_r[1] <= chan_err_nxt[1];
            grp_err_r     <= grp_err_nxt;
        end
    end

    // ****************************************
    // module and internal bytes
    // ****************************************
    logic [7:0]  mod_err_r;
    logic [7:0]  mod_err_nxt;
    logic [7:0]  int_err_r;
    logic [7:0]  int_err_nxt;

    always_comb
    begin
        mod_err_nxt = 8'h00;
        mod_err_nxt[tcd_pkg::ME_FAIL]  = MOD_FAIL;
        mod_err_nxt[tcd_pkg::ME_INT]   = INT_ERR;
        mod_err_nxt[tcd_pkg::ME_EXT]   = EXT_ERR;
        mod_err_nxt[tcd_pkg::ME_CHAN]  = |grp_err_nxt;
        mod_err_nxt[tcd_pkg::ME_AUX]   = AUX_MISSING;
        mod_err_nxt[tcd_pkg::ME_PARAM] = PARAM_ERR;
        int_err_nxt = 8'h00;
        int_err_nxt[tcd_pkg::IE_OVF]  = BUF_OVERFLOW;
        int_err_nxt[tcd_pkg::IE_COMM] = COMM_ERR;
    end

    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            mod_err_r <= 8'h00;
            int_err_r <= 8'h00;
        end
        else
        begin
            mod_err_r <= mod_err_nxt;
            int_err_r <= int_err_nxt;
        end
    end

    // ****************************************
    // diagnostic timestamp
    // ****************************************
    logic [31:0] stamp_r;
    logic [31:0] stamp_nxt;
    logic        event_hit;

    always_comb
    begin
        event_hit = |(new_bits(mod_err_nxt, mod_err_r)
                    | new_bits(int_err_nxt, int_err_r)
                    | new_bits(chan_err_nxt[0], chan_err_r[0])
                    | new_bits(chan_err_nxt[1], chan_err_r[1]));
        stamp_nxt = event_hit ? tick_r : stamp_r;
    end

    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            stamp_r <= 32'h0000_0000;
        end
        else
        begin
            stamp_r <= stamp_nxt;
        end
    end

    // ****************************************
    // record read port
    // ****************************************
    function automatic logic [7:0] rec_byte(input logic [7:0] sub);
        logic [7:0] b;
        b = 8'h00;
        unique case (sub)
            tcd_pkg::SUB_FIRST:   b = mod_err_r;
            tcd_pkg::SUB_CLASS:   b = {3'h0, 1'b1, tcd_pkg::CLASS_ANALOG};
            tcd_pkg::SUB_INTERR:  b = int_err_r;
            tcd_pkg::SUB_KIND:    b = {1'b0, tcd_pkg::KIND_AI};
            tcd_pkg::SUB_NUMBITS: b = tcd_pkg::NUM_BITS;
            tcd_pkg::SUB_CHANNEL_COUNT:   b = tcd_pkg::NUM_CH;
            tcd_pkg::SUB_GRPERR:  b = grp_err_r;
            tcd_pkg::SUB_CH0:     b = chan_err_r[0];
            tcd_pkg::SUB_CH1:     b = chan_err_r[1];
            tcd_pkg::SUB_RSVD2:   b = 8'h00;
            tcd_pkg::SUB_STAMP:   b = stamp_r[7:0];
            tcd_pkg::SUB_STAMP + 8'h01: b = stamp_r[15:8];
            tcd_pkg::SUB_STAMP + 8'h02: b = stamp_r[23:16];
            tcd_pkg::SUB_STAMP + 8'h03: b = stamp_r[31:24];
            default:              b = 8'h00;
        endcase
        return b;
    endfunction : rec_byte

    // ****************************************
    // read answer
    // ****************************************
    logic       ack_nxt;
    logic       err_nxt;
    logic [7:0] data_nxt;
    logic       full_sel;
    logic       short_sel;
    logic       in_full;
    logic       in_short;

    always_comb
    begin
        full_sel  = addr_hit(RD_BY_INDEX, RECORD_SET_NUMBER, OBJECT_INDEX,
                             tcd_pkg::SET_FULL, tcd_pkg::IDX_FULL);
        short_sel = addr_hit(RD_BY_INDEX, RECORD_SET_NUMBER, OBJECT_INDEX,
                             tcd_pkg::SET_SHORT, tcd_pkg::IDX_SHORT);
        in_full   = sub_in(OBJECT_SUBINDEX, tcd_pkg::FULL_LEN);
        in_short  = sub_in(OBJECT_SUBINDEX, tcd_pkg::SHORT_LEN);
        ack_nxt   = RD_REQ;
        err_nxt   = 1'b0;
        data_nxt  = 8'h00;
        if (RD_REQ)
        begin
            if ((full_sel && in_full) || (short_sel && in_short))
                data_nxt = rec_byte(OBJECT_SUBINDEX);
            else
                err_nxt = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            RD_ACK  <= 1'b0;
            RD_ERR  <= 1'b0;
            RD_DATA <= 8'h00;
        end
        else
        begin
            RD_ACK  <= ack_nxt;
            RD_ERR  <= err_nxt;
            RD_DATA <= data_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // channel indicators, no interrupt
    assign CH_LED    = grp_err_r[1:0];
    assign US_TICKER = tick_r;
endmodule : tcd_diag_record

// ### dv/tcd_diag_props.sv
// checker: read answers, fixed bytes, ticker and indicators
`timescale 1ns/1ps
module tcd_diag_props (
    input wire logic        CLK_SYS,
    input wire logic        RSTN,
    input wire logic [1:0]  CH_OVERFLOW,
    input wire logic        RD_REQ,
    input wire logic        RD_BY_INDEX,
    input wire logic [7:0]  RECORD_SET_NUMBER,
    input wire logic [7:0]  OBJECT_SUBINDEX,
    input wire logic        RD_ACK,
    input wire logic        RD_ERR,
    input wire logic [7:0]  RD_DATA,
    input wire logic [1:0]  CH_LED,
    input wire logic [31:0] US_TICKER
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    logic full;
    assign full = RD_REQ && !RD_BY_INDEX && RECORD_SET_NUMBER == 8'h01;
    property p_ack; RD_REQ |=> RD_ACK; endproperty
    a_ack: assert property (p_ack) else $error("request not acked");
    property p_idle; !RD_REQ |=> !RD_ACK && RD_DATA == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("answer w/o req");
    property p_kind; full && OBJECT_SUBINDEX == 8'h06
        |=> RD_DATA == 8'h71 && !RD_ERR; endproperty
    a_kind: assert property (p_kind) else $error("bad kind");
    property p_class; full && OBJECT_SUBINDEX == 8'h03
        |=> RD_DATA == 8'h15; endproperty
    a_class: assert property (p_class) else $error("bad class");
    property p_bits; full && OBJECT_SUBINDEX == 8'h07
        |=> RD_DATA == 8'h08; endproperty
    a_bits: assert property (p_bits) else $error("bad bit count");
    property p_cnt; full && OBJECT_SUBINDEX == 8'h08
        |=> RD_DATA == 8'h02; endproperty
    a_cnt: assert property (p_cnt) else $error("bad chan count");
    property p_short; RD_REQ && !RD_BY_INDEX && RECORD_SET_NUMBER == 8'h00
        && OBJECT_SUBINDEX > 8'h05 |=> RD_ERR && RD_DATA == 8'h00; endproperty
    a_short: assert property (p_short) else $error("short read");
    property p_tick; US_TICKER != $past(US_TICKER)
        |-> US_TICKER == $past(US_TICKER) + 32'h1; endproperty
    a_tick: assert property (p_tick) else $error("ticker step");
    property p_led; CH_OVERFLOW[0] [*3] |-> CH_LED[0]; endproperty
    a_led: assert property (p_led) else $error("led dark");
endmodule : tcd_diag_props
bind tcd_diag_record tcd_diag_props u_props (.CLK_SYS(CLK_SYS),
    .RSTN(RSTN), .CH_OVERFLOW(CH_OVERFLOW), .RD_REQ(RD_REQ),
    .RD_BY_INDEX(RD_BY_INDEX), .RECORD_SET_NUMBER(RECORD_SET_NUMBER),
    .OBJECT_SUBINDEX(OBJECT_SUBINDEX), .RD_ACK(RD_ACK), .RD_ERR(RD_ERR),
    .RD_DATA(RD_DATA), .CH_LED(CH_LED), .US_TICKER(US_TICKER));

// ### dv/tcd_coupler.sv
// model: coupler reading record bytes one at a time
`timescale 1ns/1ps
module tcd_coupler (
    input  wire logic        clk_sys,
    input  wire logic        rd_ack,
    input  wire logic        rd_err,
    input  wire logic [7:0]  rd_data,
    output logic             rd_req = 1'b0,
    output logic             rd_by_index = 1'b0,
    output logic [7:0]       record_set_number = 8'hFF,
    output logic [15:0]      object_index = 16'hFFFF,
    output logic [7:0]       object_subindex = 8'hFF
);
    // ****************************************
    // read cycle
    // ****************************************
    // one pulse per byte
    task automatic rd(input logic b, input logic [7:0] st,
        input logic [15:0] ix, input logic [7:0] sb, input int gap,
        output logic [7:0] d, output logic e, output logic ok);
        ok = 1'b0;
        repeat (gap + 1) @(negedge clk_sys);
        rd_req = 1'b1;
        rd_by_index = b;
        record_set_number = st;
        object_index = ix;
        object_subindex = sb;
        @(negedge clk_sys);
        rd_req = 1'b0;
        record_set_number = ~st;
        object_index = ~ix;
        object_subindex = ~sb;
        for (int k = 0; k < 3 && !ok; k++)
        begin
            if (k > 0)
                @(negedge clk_sys);
            ok = (rd_ack === 1'b1);
            d = rd_data;
            e = rd_err;
        end
    endtask : rd
endmodule : tcd_coupler

// ### dv/testbench.sv
// testbench: random error levels against a record model
`timescale 1ns/1ps
module testbench;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [14:0] flt = 15'h0000;
    logic req, bi, ack, err;
    logic [7:0] st, sb, dat;
    logic [7:0] rdv;
    logic [15:0] ix;
    logic [1:0] led;
    logic [31:0] tick, tsv;
    int cyc, ts_m, bad_count, compares;
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys or negedge rstn) cyc <= rstn ? cyc + 1 : 0;
    tcd_diag_record dut (.CLK_SYS(clk_sys), .RSTN(rstn), .MOD_FAIL(flt[0]),
        .INT_ERR(flt[1]), .EXT_ERR(flt[2]), .AUX_MISSING(flt[3]),
        .PARAM_ERR(flt[4]), .BUF_OVERFLOW(flt[5]), .COMM_ERR(flt[6]),
        .CH_PARAM_ERR(flt[8:7]), .CH_WIRE_BREAK(flt[10:9]),
        .CH_UNDERFLOW(flt[12:11]), .CH_OVERFLOW(flt[14:13]), .RD_REQ(req),
        .RD_BY_INDEX(bi), .RECORD_SET_NUMBER(st), .OBJECT_INDEX(ix),
        .OBJECT_SUBINDEX(sb), .RD_ACK(ack), .RD_ERR(err), .RD_DATA(dat),
        .CH_LED(led), .US_TICKER(tick));
    tcd_coupler u_bus (.clk_sys(clk_sys), .rd_ack(ack), .rd_err(err),
        .rd_data(dat), .rd_req(req), .rd_by_index(bi),
        .record_set_number(st), .object_index(ix), .object_subindex(sb));
    // ****************************************
    // model and checks
    // ****************************************
    function automatic logic [7:0] exp_byte(input logic [7:0] s);
        logic [7:0] c0, c1, g;
        c0 = {flt[13], flt[11], 1'h0, flt[9], 3'h0, flt[7]};
        c1 = {flt[14], flt[12], 1'h0, flt[10], 3'h0, flt[8]};
        g = {6'h00, |c1, |c0};
        case (s)
            8'h02: exp_byte = {flt[4], 2'h0, flt[3], |g, flt[2:0]};
            8'h03: exp_byte = 8'h15;
            8'h05: exp_byte = {3'h0, flt[6:5], 3'h0};
            8'h06: exp_byte = 8'h71;
            8'h07: exp_byte = 8'h08;
            8'h08: exp_byte = 8'h02;
            8'h09: exp_byte = g;
            8'h0A: exp_byte = c0;
            8'h0B: exp_byte = c1;
            default: exp_byte = 8'h00;
        endcase
    endfunction : exp_byte
    task automatic give_verdict();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        compares++;
        if (got !== want)
        begin
            bad_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, want);
        end
    endtask : chk
    task automatic rdc(input logic b, input logic [7:0] st_, input
        logic [15:0] ix_, input logic [7:0] s, input int w, output
        logic [7:0] d);
        logic e, ok;
        u_bus.rd(b, st_, ix_, s, $urandom_range(2), d, e, ok);
        if (ok !== 1'b1)
        begin
            bad_count++;
            $display("[FAIL] %0t ack %h want %h", $time, ok, 1'b1);
            give_verdict();
        end
        chk({7'h00, e}, {7'h00, w == -1});
        if (w > -2)
            chk(d, (w < 0) ? 8'h00 : w[7:0]);
    endtask : rdc
    task automatic upd(input logic [14:0] v);
        if ((v & ~flt) != 15'h0000)
            ts_m = cyc / 100;
        flt = v;
    endtask : upd
    initial
    begin
        void'($urandom(87893));
        repeat (10) @(negedge clk_sys);
        rstn = 1'b1;
        chk({7'h00, tick != 0}, 8'h00);
        for (int n = 0; n < 12; n++)
        begin
            for (int s = 2; s < 19; s++)
                rdc(n[0], 8'h01, 16'h2F01, 8'(s), exp_byte(8'(s)), rdv);
            for (int s = 2; s < 6; s++)
                rdc(n[1], 8'h00, 16'h2F00, 8'(s), exp_byte(8'(s)), rdv);
            rdc(1'b0, 8'h02, 16'h2F01, 8'h02, -1, rdv);
            rdc(1'b1, 8'h01, 16'h2F02, 8'h02, -1, rdv);
            rdc(n[1], 8'h01, 16'h2F01, 8'h01, -1, rdv);
            rdc(1'b0, 8'h01, 16'h2F01, 8'h17, -2, rdv);
            rdc(n[0], 8'h00, 16'h2F00, 8'h06, -1, rdv);
            for (int s = 0; s < 4; s++)
                rdc(n[2], 8'h01, 16'h2F01, 8'(8'h13 + s), -2, tsv[8*s+:8]);
            chk({7'h00, (tsv - ts_m + 1) > 2}, 8'h00);
            chk({7'h00, (tick - cyc / 100 + 1) > 2}, 8'h00);
            chk({6'h00, led}, exp_byte(8'h09));
            if (n == 6)
            begin
                rstn = 1'b0;
                ts_m = 0;
                repeat (10) @(negedge clk_sys);
                rstn = 1'b1;
            end
            @(negedge clk_sys);
            upd((n < 2) ? 15'h0000 : (n == 2) ? 15'h2000
                : 15'($urandom & $urandom));
            repeat (3) @(negedge clk_sys);
        end
        give_verdict();
    end
endmodule : testbench
